/* File: iopg_core_model.sv */
// Core model: issues port reads, writes and byte writes.
// Assumes tasks are called just after a ref_clk rising edge.
`timescale 1ns/1ns
`default_nettype none
module iopg_core_model
  import iopg_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Port access
  output logic [4:0] port_addr,
  output logic port_rd,
  output logic port_wr,
  output logic [1:0] port_wr_kind,
  output logic [3:0] port_wdata,
  output logic [1:0] port_bit,
  output logic byte_wr,
  output logic [7:0] byte_wdata,
  input wire logic [3:0] port_rdata
);
  initial {port_addr, port_rd, port_wr, port_wr_kind, port_wdata, port_bit, byte_wr, byte_wdata} = '0;

  // One access, then an idle cycle with data inverted
  task automatic wr(input logic [4:0] a, input logic [1:0] k, input logic [1:0] b, input logic [3:0] d);
    port_addr = a;
    port_wr_kind = k;
    port_bit = b;
    port_wdata = d;
    port_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    port_wr = 1'b0;
    port_wdata = ~d;
    @(posedge ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [3:0] d);
    port_addr = a;
    port_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    port_rd = 1'b0;
    d = port_rdata;
    @(posedge ref_clk);
    #1;
  endtask : rd

  // byte to ports a and b
  task automatic bw(input logic [7:0] d);
    byte_wdata = d;
    byte_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    byte_wr = 1'b0;
    byte_wdata = ~d;
    @(posedge ref_clk);
    #1;
  endtask : bw
endmodule : iopg_core_model
`default_nettype wire

/* File: iopg_monitor.sv */
// Checker for the I/O port group.
// Assumes it is bound to iopg_top.
`timescale 1ns/1ns
`default_nettype none
module iopg_monitor
  import iopg_pkg::*;
(
  // Clock, reset, option
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tristate_mask_option,
  // Core access
  input wire logic [4:0] port_addr,
  input wire logic port_rd,
  input wire logic port_wr,
  input wire logic [1:0] port_wr_kind,
  input wire logic [3:0] port_wdata,
  input wire logic byte_wr,
  input wire logic [7:0] byte_wdata,
  input wire logic [3:0] port_rdata,
  // Ports
  input wire logic [3:0] output_port_a,
  input wire logic [3:0] output_port_b,
  input wire logic [3:0] tri_pin_out,
  input wire logic [3:0] tri_pin_oe,
  input wire logic [3:0] pwm_alt_out,
  input wire logic [3:0] pwm_pin_oe,
  input wire logic [3:0] hold_mode_control
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic wr0 = port_wr && !byte_wr && port_wr_kind == WR_REG;

  property p_rst; $rose(arst_n) |-> output_port_a == 4'hf && tri_pin_oe == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_toff; wr0 && port_addr == ADDR_ANALOG && !port_wdata[3] && tristate_mask_option
    |-> ##2 tri_pin_oe == 4'h0; endproperty
  a_toff: assert property (p_toff) else $error("tri off");
  property p_tdrv; wr0 && port_addr == ADDR_TRI && tristate_mask_option ##1 tri_pin_oe == 4'hf
    |-> ##1 tri_pin_out == $past(port_wdata, 2); endproperty
  a_tdrv: assert property (p_tdrv) else $error("tri data");
  property p_od; !tristate_mask_option && !$past(tristate_mask_option) |-> tri_pin_out == 4'h0; endproperty
  a_od: assert property (p_od) else $error("open drain");
  property p_pwm; wr0 && port_addr == ADDR_PWM
    |-> ##2 pwm_pin_oe == ~($past(port_wdata, 2) & $past(pwm_alt_out)); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm pin");
  property p_byte; byte_wr |-> ##2 {output_port_b, output_port_a} == $past(byte_wdata, 2); endproperty
  a_byte: assert property (p_byte) else $error("byte out");
  property p_unm; port_rd && port_addr == 5'h03 |=> port_rdata == 4'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; port_wr && port_addr == ADDR_HOLD_CTL && port_wr_kind != WR_REG
    |=> $stable(hold_mode_control) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("hold write");
endmodule : iopg_monitor

bind iopg_top iopg_monitor i_mon (.ref_clk, .arst_n, .tristate_mask_option, .port_addr, .port_rd,
  .port_wr, .port_wr_kind, .port_wdata, .byte_wr, .byte_wdata, .port_rdata, .output_port_a,
  .output_port_b, .tri_pin_out, .tri_pin_oe, .pwm_alt_out, .pwm_pin_oe, .hold_mode_control);
`default_nettype wire

/* File: iopg_pkg.sv */
// Package for the I/O port group: port addresses, reset values, instruction kinds.
// Assumes a 4-bit core that issues one port access per cycle.
package iopg_pkg;
  localparam logic [4:0] ADDR_KEY = 5'h00;
  localparam logic [4:0] ADDR_OUT_A = 5'h01;
  localparam logic [4:0] ADDR_OUT_B = 5'h02;
  localparam logic [4:0] ADDR_PWM = 5'h04;
  localparam logic [4:0] ADDR_GEN_C = 5'h05;
  localparam logic [4:0] ADDR_TRI = 5'h06;
  localparam logic [4:0] ADDR_GEN_D = 5'h07;
  localparam logic [4:0] ADDR_INT_TMR = 5'h08;
  localparam logic [4:0] ADDR_ANALOG = 5'h09;
  localparam logic [4:0] ADDR_HOLD_ST = 5'h0e;
  localparam logic [4:0] ADDR_HOLD_CTL = 5'h10;
  localparam logic [4:0] ADDR_CMP_CTL = 5'h12;
  localparam logic [3:0] RST_LATCH4 = 4'hf;
  localparam logic [2:0] RST_LATCH3 = 3'h7;
  localparam logic [3:0] RST_ZERO4 = 4'h0;
  localparam int ENABLE_BIT = 3;
  localparam int CMP_PIN_BIT = 2;
  localparam int CMP_RES_BIT = 3;
  // Write kinds of the core's output instructions
  typedef enum logic [1:0] {
    WR_REG = 2'b00,
    WR_IMM = 2'b01,
    WR_SET = 2'b10,
    WR_CLR = 2'b11
  } iopg_wr_kind_t;
endpackage : iopg_pkg

/* File: iopg_top.sv */
// I/O port group of a 4-bit controller: latches, pin drivers, input read path.
// Assumes the core presents one access per cycle on ref_clk; pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module iopg_top
  import iopg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Mask option: 1 selects tri-state, 0 selects open-drain
  input wire logic tristate_mask_option,
  // Core port access
  input wire logic [4:0] port_addr,
  input wire logic port_rd,
  input wire logic port_wr,
  input wire logic [1:0] port_wr_kind,
  input wire logic [3:0] port_wdata,
  input wire logic [1:0] port_bit,
  input wire logic byte_wr,
  input wire logic [7:0] byte_wdata,
  output logic [3:0] port_rdata,
  // Key input and output ports
  input wire logic [3:0] key_input_port,
  output logic [3:0] output_port_a,
  output logic [3:0] output_port_b,
  // PWM-shared port
  input wire logic [3:0] pwm_alt_out,
  input wire logic [3:0] pwm_pin_in,
  output logic [3:0] pwm_pin_out,
  output logic [3:0] pwm_pin_oe,
  // General ports C and D (open-drain style)
  input wire logic [3:0] gen_c_pin_in,
  output logic [3:0] gen_c_pin_out,
  output logic [3:0] gen_c_pin_oe,
  input wire logic [3:0] gen_d_pin_in,
  output logic [3:0] gen_d_pin_out,
  output logic [3:0] gen_d_pin_oe,
  // Tri-state port
  input wire logic [3:0] tri_pin_in,
  output logic [3:0] tri_pin_out,
  output logic [3:0] tri_pin_oe,
  // Interrupt and timer port
  input wire logic [3:0] int_tmr_pin_in,
  output logic [3:0] int_tmr_pin_out,
  output logic [3:0] int_tmr_pin_oe,
  output logic [3:0] int_tmr_level,
  // Analog-shared port
  input wire logic [2:0] ana_pin_in,
  output logic [2:0] ana_pin_out,
  output logic [2:0] ana_pin_oe,
  input wire logic comparator_input,
  // Hold status and control
  input wire logic [3:0] hold_state_input,
  output logic [3:0] hold_mode_control,
  output logic [3:0] comparator_control
);

  // Three-stage pin synchronisers
  logic [31:0] s1_r;
  logic [31:0] s2_r;
  logic [31:0] s3_r;
  logic [31:0] clean_r;
  logic [31:0] raw_in;
  assign raw_in = {key_input_port, pwm_pin_in, gen_c_pin_in, tri_pin_in, gen_d_pin_in,
                   int_tmr_pin_in, comparator_input, ana_pin_in, hold_state_input};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
    end
    else
    begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Bits change once stages two and three agree
      clean_r <= (clean_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
    end
  end

  logic [3:0] key_s, pwm_s, genc_s, tri_s, gend_s, it_s, hold_s;
  logic [2:0] ana_s;
  logic cmp_s;
  assign {key_s, pwm_s, genc_s, tri_s, gend_s, it_s, cmp_s, ana_s, hold_s} = clean_r;

  // Apply one write kind to a 4-bit latch
  function automatic logic [3:0] upd(input logic [3:0] cur, input logic [1:0] kind,
                                     input logic [3:0] d, input logic [1:0] b);
    logic [3:0] r;
    r = cur;
    case (kind)
      WR_SET: r[b] = 1'b1;
      WR_CLR: r[b] = 1'b0;
      default: r = d;
    endcase
    return r;
  endfunction : upd

  function automatic logic hit(input logic [4:0] a, input logic [4:0] p, input logic w);
    return w && (a == p);
  endfunction : hit

  logic [3:0] out_a_r, out_b_r, pwm_r, genc_r, tri_r, gend_r, it_r, hold_r, cmpc_r;
  logic [2:0] ana_r;
  logic tri_en_r;

  // Address 09 feeds two fields: latch bits 2:0 and the enable in bit 3
  logic [3:0] ana_upd;
  logic [3:0] en_upd;
  assign ana_upd = upd({1'b0, ana_r}, port_wr_kind, port_wdata, port_bit);
  assign en_upd = upd({tri_en_r, 3'b000}, port_wr_kind, port_wdata, port_bit);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_a_r <= RST_LATCH4;
      out_b_r <= RST_LATCH4;
    end
    else if (byte_wr)
    begin
      out_a_r <= byte_wdata[3:0];
      out_b_r <= byte_wdata[7:4];
    end
    else
    begin
      if (hit(port_addr, ADDR_OUT_A, port_wr))
        out_a_r <= upd(out_a_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_OUT_B, port_wr))
        out_b_r <= upd(out_b_r, port_wr_kind, port_wdata, port_bit);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwm_r <= RST_LATCH4;
      genc_r <= RST_LATCH4;
      tri_r <= RST_LATCH4;
      gend_r <= RST_LATCH4;
      it_r <= RST_LATCH4;
      ana_r <= RST_LATCH3;
    end
    else
    begin
      if (hit(port_addr, ADDR_PWM, port_wr))
        pwm_r <= upd(pwm_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_GEN_C, port_wr))
        genc_r <= upd(genc_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_TRI, port_wr))
        tri_r <= upd(tri_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_GEN_D, port_wr))
        gend_r <= upd(gend_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_INT_TMR, port_wr))
        it_r <= upd(it_r, port_wr_kind, port_wdata, port_bit);
      if (hit(port_addr, ADDR_ANALOG, port_wr))
        ana_r <= ana_upd[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      tri_en_r <= 1'b0;
    else if (hit(port_addr, ADDR_ANALOG, port_wr) && tristate_mask_option)
      tri_en_r <= en_upd[ENABLE_BIT];
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_r <= RST_ZERO4;
      cmpc_r <= RST_ZERO4;
    end
    else if (port_wr && port_wr_kind == WR_REG)
    begin
      if (port_addr == ADDR_HOLD_CTL)
        hold_r <= port_wdata;
      if (port_addr == ADDR_CMP_CTL)
        cmpc_r <= port_wdata;
    end
  end

  // Read path, registered
  logic [3:0] rd_nxt;
  always_comb
  begin
    case (port_addr)
      ADDR_KEY: rd_nxt = key_s;
      ADDR_OUT_A: rd_nxt = out_a_r;
      ADDR_OUT_B: rd_nxt = out_b_r;
      ADDR_PWM: rd_nxt = pwm_s;
      ADDR_GEN_C: rd_nxt = genc_s;
      ADDR_TRI: rd_nxt = tri_s;
      ADDR_GEN_D: rd_nxt = gend_s;
      ADDR_INT_TMR: rd_nxt = it_s;
      ADDR_ANALOG: rd_nxt = {cmp_s, ana_s};
      ADDR_HOLD_ST: rd_nxt = hold_s;
      default: rd_nxt = RST_ZERO4;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      port_rdata <= RST_ZERO4;
    else if (port_rd)
      port_rdata <= rd_nxt;
  end

  // Pin drivers, all registered
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_port_a <= RST_LATCH4;
      output_port_b <= RST_LATCH4;
      pwm_pin_out <= RST_ZERO4;
      pwm_pin_oe <= RST_ZERO4;
      gen_c_pin_out <= RST_ZERO4;
      gen_c_pin_oe <= RST_ZERO4;
      gen_d_pin_out <= RST_ZERO4;
      gen_d_pin_oe <= RST_ZERO4;
      tri_pin_out <= RST_ZERO4;
      tri_pin_oe <= RST_ZERO4;
      int_tmr_pin_out <= RST_ZERO4;
      int_tmr_pin_oe <= RST_ZERO4;
      int_tmr_level <= RST_ZERO4;
      ana_pin_out <= 3'h0;
      ana_pin_oe <= 3'h0;
      hold_mode_control <= RST_ZERO4;
      comparator_control <= RST_ZERO4;
    end
    else
    begin
      output_port_a <= out_a_r;
      output_port_b <= out_b_r;
      pwm_pin_out <= RST_ZERO4;
      pwm_pin_oe <= ~(pwm_r & pwm_alt_out);
      gen_c_pin_out <= RST_ZERO4;
      gen_c_pin_oe <= ~genc_r;
      gen_d_pin_out <= RST_ZERO4;
      gen_d_pin_oe <= ~gend_r;
      if (tristate_mask_option)
      begin
        tri_pin_out <= tri_r;
        tri_pin_oe <= {4{tri_en_r}};
      end
      else
      begin
        tri_pin_out <= RST_ZERO4;
        tri_pin_oe <= ~tri_r;
      end
      int_tmr_pin_out <= RST_ZERO4;
      int_tmr_pin_oe <= ~it_r;
      int_tmr_level <= it_s;
      ana_pin_out <= 3'h0;
      ana_pin_oe <= ~ana_r;
      hold_mode_control <= hold_r;
      comparator_control <= cmpc_r;
    end
  end

endmodule : iopg_top
`default_nettype wire

/* File: tb_io_port_group_with_tristate.sv */
// Bench for the I/O port group: core model in front, pins driven here.
// Assumes design, core model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_io_port_group_with_tristate;
  import iopg_pkg::*;
  logic ref_clk = 0, arst_n = 0, tristate_mask_option = 1, comparator_input = 0, port_rd, port_wr, byte_wr;
  logic [4:0] port_addr;
  logic [1:0] port_wr_kind, port_bit;
  logic [7:0] byte_wdata;
  logic [3:0] port_wdata, port_rdata, output_port_a, output_port_b, pwm_pin_out, pwm_pin_oe, pwm_pin_in;
  logic [3:0] tri_pin_out, tri_pin_oe, gen_c_pin_out, gen_c_pin_oe, gen_d_pin_out, gen_d_pin_oe, rv;
  logic [3:0] int_tmr_pin_out, int_tmr_pin_oe, int_tmr_level, hold_mode_control, comparator_control;
  logic [3:0] pwm_alt_out = 4'hc, tri_pin_in = 0, int_tmr_pin_in = 0, key_input_port = 0, hold_state_input = 0;
  logic [3:0] gen_c_pin_in = 4'hf, gen_d_pin_in = 4'hf;
  logic [2:0] ana_pin_out, ana_pin_oe, ana_pin_in = 0;
  int n_errors = 0, compares = 0, cyc = 0;
  // Pull-up on pins 0 and 3, low where enabled
  assign pwm_pin_in = 4'h9 & ~pwm_pin_oe;
  iopg_top i_dut (.*);
  iopg_core_model i_core (.*);
  always #20 ref_clk = ~ref_clk;

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h want %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic cw(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cw

  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      complete_run;
    end
  end

  task automatic t_tri;
    i_core.wr(ADDR_TRI, WR_IMM, 2'd0, 4'h5);
    chk(tri_pin_oe, 4'h0);
    // Enable after data
    i_core.wr(ADDR_ANALOG, WR_SET, 2'd3, 4'h0);
    chk(tri_pin_oe, 4'hf);
    chk(tri_pin_out, 4'h5);
    i_core.wr(ADDR_TRI, WR_REG, 2'd0, 4'ha);
    chk(tri_pin_out, 4'ha);
    i_core.wr(ADDR_ANALOG, WR_REG, 2'd0, 4'h7);
    chk(tri_pin_oe, 4'h0);
    tristate_mask_option = 1'b0;
    i_core.wr(ADDR_ANALOG, WR_SET, 2'd3, 4'h0);
    i_core.wr(ADDR_TRI, WR_CLR, 2'd1, 4'h0);
    chk(tri_pin_out, 4'h0);
    chk(tri_pin_oe, 4'h7);
    tristate_mask_option = 1'b1;
    cw(2);
    chk(tri_pin_oe, 4'h0);
  endtask : t_tri

  task automatic t_pins;
    i_core.wr(ADDR_PWM, WR_REG, 2'd0, 4'h6);
    chk(pwm_pin_oe, 4'hb);
    // Latch high for input use
    i_core.wr(ADDR_PWM, WR_REG, 2'd0, 4'hf);
    chk(pwm_pin_oe, 4'h3);
    cw(8);
    i_core.rd(ADDR_PWM, rv);
    chk(rv, 4'h8);
    for (int v = 0; v < 2; v++)
    begin
      ana_pin_in = {v[0], 2'b00};
      comparator_input = !v[0];
      int_tmr_pin_in = {3'h3, v[0]};
      cw(8);
      i_core.rd(ADDR_ANALOG, rv);
      chk({3'h0, rv[2]}, {3'h0, v[0]});
      chk({3'h0, rv[3]}, {3'h0, !v[0]});
      chk(int_tmr_level, {3'h3, v[0]});
    end
  endtask : t_pins

  task automatic t_ctl;
    i_core.wr(ADDR_HOLD_CTL, WR_IMM, 2'd0, 4'h5);
    chk(hold_mode_control, 4'h0);
    i_core.wr(ADDR_HOLD_CTL, WR_REG, 2'd0, 4'h5);
    chk(hold_mode_control, 4'h5);
    i_core.wr(ADDR_CMP_CTL, WR_SET, 2'd1, 4'h0);
    chk(comparator_control, 4'h0);
    i_core.wr(ADDR_CMP_CTL, WR_REG, 2'd0, 4'h6);
    chk(comparator_control, 4'h6);
    i_core.rd(5'h03, rv);
    chk(rv, 4'h0);
    i_core.bw(8'ha5);
    chk(output_port_a, 4'h5);
    chk(output_port_b, 4'ha);
  endtask : t_ctl

  task automatic t_ports;
    key_input_port = 4'h6;
    i_core.wr(ADDR_GEN_C, WR_REG, 2'd0, 4'h5);
    chk(gen_c_pin_oe, 4'ha);
    i_core.wr(ADDR_GEN_D, WR_CLR, 2'd2, 4'h0);
    chk(gen_d_pin_oe, 4'h4);
    i_core.wr(ADDR_INT_TMR, WR_IMM, 2'd0, 4'h9);
    chk(int_tmr_pin_oe, 4'h6);
    i_core.wr(ADDR_ANALOG, WR_REG, 2'd0, 4'h3);
    chk({1'b0, ana_pin_oe}, 4'h4);
    chk(pwm_pin_out | gen_c_pin_out | gen_d_pin_out | int_tmr_pin_out | {1'b0, ana_pin_out}, 4'h0);
    i_core.rd(ADDR_KEY, rv);
    chk(rv, 4'h6);
  endtask : t_ports

  initial
  begin
    cw(10);
    arst_n = 1'b1;
    cw(1);
    chk(pwm_pin_oe, ~(RST_LATCH4 & pwm_alt_out));
    chk({1'b0, ana_pin_oe}, 4'h0);
    chk(tri_pin_oe, 4'h0);
    t_tri;
    t_pins;
    t_ctl;
    t_ports;
    complete_run;
  end
endmodule : tb_io_port_group_with_tristate
`default_nettype wire
